// ---- dv/comm_unit_model.sv ----
`timescale 1ns/1ps
module comm_unit_model (
   // Clock
   input  wire logic pclk,
   // Process data
   output logic [3:0] bus_val,
   output logic [3:0] bus_inv,
   output logic       bus_upd,
   // Link health
   output logic       comm_ok,
   output logic       comm_fail
);
   initial begin
      bus_val   = 4'h0;
      bus_inv   = 4'h0;
      bus_upd   = 1'b0;
      comm_ok   = 1'b0;
      comm_fail = 1'b0;
   end

   task automatic send(input logic [3:0] v, input logic [3:0] s);
      @(posedge pclk);
      bus_val <= v;
      bus_inv <= s;
      bus_upd <= 1'b1;
      @(posedge pclk);
      bus_upd <= 1'b0;
      // Stale lines flip, so a late sample cannot pass
      bus_val <= ~v;
      bus_inv <= ~s;
   endtask

   task automatic attempt(input logic good);
      @(posedge pclk);
      comm_ok   <= good;
      comm_fail <= !good;
      @(posedge pclk);
      comm_ok   <= 1'b0;
      comm_fail <= 1'b0;
   endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   localparam int WD = 200;
   localparam int MS = 10;
   localparam int TP = 1000;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  lf_in = 4'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, bus_upd, comm_ok, comm_fail, irq, err;
   logic [3:0]  bus_val, bus_inv, rsp_invalid, valve_out;
   logic [3:0]  test_pulse, line_fault, seen;
   int          n_fail = 0;
   int          n_checks = 0;
   // cfg, then nibbles: bus value, invalid flag, output, invalid report
   logic [47:0] rows [13] = '{48'h00000010_1010, 48'h00000010_0000,
      48'h00000018_1000, 48'h00000018_0010, 48'h00000091_0010,
      48'h00000011_1000, 48'h00000010_1110, 48'h00000016_0100,
      48'h00000052_0111, 48'h00000012_1101, 48'h00000014_1010,
      48'h00000014_0110, 48'h00000151_1011};

   always #2.5 pclk = ~pclk;

   valve_output_channel_control #(
      .WD_CYCLES(WD), .MS_CYCLES(MS), .TP_PERIOD(TP)
   ) u_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bus_val, .bus_inv, .bus_upd,
      .comm_ok, .comm_fail, .rsp_invalid, .valve_out, .test_pulse,
      .line_fault_in(lf_in), .line_fault, .irq);

   comm_unit_model u_cu (.pclk, .bus_val, .bus_inv, .bus_upd, .comm_ok,
      .comm_fail);

   task automatic check(input string what, input logic [31:0] s,
      input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // Master waits on pready; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic results;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      results;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, 8'h10, rows[i][47:16]);
         u_cu.send({3'h0, rows[i][12]}, {3'h0, rows[i][8]});
         tick(4);
         check("out0", valve_out[0], rows[i][4]);
         check("inv0", rsp_invalid[0], rows[i][0]);
      end
      apb(1'b1, 8'h10, 32'h10);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h1C, 32'h30);
      u_cu.send(4'h1, 4'h0);
      seen = 4'h0;
      repeat (TP + 20) begin
         tick(1);
         seen |= test_pulse;
      end
      check("pulse", seen, 4'h2);
      apb(1'b1, 8'h10, 32'h0202_0010);
      u_cu.send(4'h0, 4'h0);
      tick(4);
      check("off_dly", valve_out[0], 1'b1);
      tick(30);
      check("off_end", valve_out[0], 1'b0);
      u_cu.send(4'h1, 4'h0);
      tick(4);
      check("on_dly", valve_out[0], 1'b0);
      tick(30);
      check("on_end", valve_out[0], 1'b1);
      apb(1'b1, 8'h10, 32'h12);
      apb(1'b1, 8'h0C, 32'h1);
      @(posedge pclk);
      lf_in <= 4'h7;
      tick(6);
      check("lf", line_fault, 4'h3);
      check("lf_out", valve_out[0], 1'b1);
      check("lf_inv", rsp_invalid[0], 1'b0);
      check("irq", irq, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check("stat", rd[3:0], 4'h3);
      apb(1'b1, 8'h08, 32'h1);
      tick(1);
      check("irq_clr", irq, 1'b0);
      apb(1'b0, 8'h40, 32'h0);
      check("bad_err", err, 1'b1);
      check("bad_rd", rd, 32'h0);
      lf_in <= 4'h0;
      apb(1'b1, 8'h10, 32'h52);
      u_cu.send(4'h0, 4'h0);
      u_cu.attempt(1'b0);
      u_cu.attempt(1'b0);
      u_cu.attempt(1'b1);
      u_cu.attempt(1'b0);
      u_cu.attempt(1'b0);
      tick(4);
      check("two_fail", valve_out[0], 1'b0);
      u_cu.attempt(1'b0);
      tick(4);
      check("wd_subst", valve_out[0], 1'b1);
      tick(WD + 6);
      check("wd_off", valve_out, 4'h0);
      apb(1'b0, 8'h08, 32'h0);
      check("wd_stat", rd[4], 1'b1);
      u_cu.attempt(1'b1);
      u_cu.send(4'h2, 4'h0);
      tick(4);
      check("wd_back", valve_out, 4'h2);
      apb(1'b1, 8'h00, 32'h0);
      tick(2);
      check("inact_out", valve_out, 4'h0);
      check("inact_tp", test_pulse, 4'h0);
      @(posedge pclk);
      presetn <= 1'b0;
      tick(3);
      check("rst_out", {valve_out, line_fault, irq}, 9'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      check("ctrl", rd, 32'h1);
      for (int a = 8'h10; a <= 8'h1C; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         check("ch_rst", rd, 32'h10);
      end
      results;
   end
endmodule

// ---- dv/valve_ctl_asserts.sv ----
`timescale 1ns/1ps
module valve_ctl_asserts #(
   parameter int WD_CYCLES = 200
) (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // APB
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   // Link and field
   input wire logic       comm_ok,
   input wire logic       comm_fail,
   input wire logic [3:0] valve_out,
   input wire logic [3:0] test_pulse,
   input wire logic [3:0] line_fault_in,
   input wire logic [3:0] line_fault
);
   logic [1:0]  fails_r;
   logic [31:0] pend_r;
   logic [9:0]  tp_r;

   // Own failure count, so the off check never trusts design state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fails_r <= 2'h0;
         pend_r  <= 32'h0;
         tp_r    <= 10'h0;
      end else begin
         if (comm_ok)
            fails_r <= 2'h0;
         else if (comm_fail && fails_r != 2'h3)
            fails_r <= fails_r + 2'h1;
         pend_r <= (fails_r == 2'h3 && !comm_ok) ? pend_r + 32'h1 : 32'h0;
         tp_r   <= (|test_pulse) ? tp_r + 10'h1 : 10'h0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PREADY: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   AST_SLVERR_BAD: assert property (psel && penable && !pwrite
      && paddr > 8'h1C |-> pslverr)
      else $error("unmapped read without pslverr");
   AST_SLVERR_OK: assert property (psel && penable && !pwrite
      && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped read with pslverr");
   AST_TP_VALVE: assert property ((test_pulse & $past(valve_out)) == 4'h0)
      else $error("test pulse on a driven valve");
   AST_TP_WIDTH: assert property (tp_r <= 10'h191)
      else $error("test pulse too long");
   AST_LF_SRC: assert property ((line_fault & ~($past(line_fault_in, 2)
      | $past(line_fault_in, 3) | $past(line_fault_in, 4))) == 4'h0)
      else $error("line fault without a fault at the pin");
   AST_WD_OFF: assert property (pend_r > WD_CYCLES + 4 |-> !(|valve_out))
      else $error("outputs not off after watchdog time");
   AST_RST_OUT: assert property ($rose(presetn) |->
      valve_out == 4'h0 && line_fault == 4'h0 ##1 valve_out == 4'h0)
      else $error("outputs not clear after reset");

   cover property (pend_r == WD_CYCLES + 5);
   cover property ($rose(|line_fault));
   cover property ($rose(|test_pulse));
endmodule

bind valve_output_channel_control valve_ctl_asserts #(
   .WD_CYCLES(WD_CYCLES)
) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
   .pslverr, .comm_ok, .comm_fail, .valve_out, .test_pulse,
   .line_fault_in, .line_fault);

// ---- hdl/valve_channel.sv ----
`timescale 1ns/1ps
module valve_channel (
   // Clock, reset, enable and ms_tick
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   input  wire logic       ms_tick,
   // Channel configuration
   input  wire logic       sim_mode,
   input  wire logic [1:0] err_mode,
   input  wire logic       invert,
   input  wire logic       subst_val,
   input  wire logic       sim_val,
   input  wire logic       sim_invalid,
   input  wire logic [7:0] on_delay,
   input  wire logic [7:0] off_delay,
   // Bus value and module conditions
   input  wire logic       bus_val,
   input  wire logic       bus_inv,
   input  wire logic       bus_upd,
   input  wire logic       wd_err,
   input  wire logic       force_off,
   // Results
   output logic            valve_out,
   output logic            last_valid
);

   typedef struct packed {
      logic       last;
      logic       out;
      logic [7:0] cnt;
   } ch_state_t;

   ch_state_t r;
   ch_state_t n;

   assign valve_out  = r.out;
   assign last_valid = r.last;

   always_comb begin
      logic src;
      logic fault;
      logic val;
      logic tgt;
      val   = 1'b0;
      tgt   = 1'b0;
      src   = sim_mode ? sim_val : bus_val;
      fault = wd_err | (sim_mode ? 1'b0 : bus_inv);
      n     = r;
      if (bus_upd && !bus_inv && !wd_err) begin
         n.last = bus_val;
      end
      if (sim_mode && sim_invalid) begin
         val = subst_val;
      end else if (fault) begin
         unique case (err_mode)
            valve_out_pkg::ERR_SUBST: val = subst_val;
            valve_out_pkg::ERR_LAST:  val = r.last;
            default:                  val = src;
         endcase
      end else begin
         val = src;
      end
      tgt = val ^ invert;
      // Off wins over any delay so a dead link never leaves a valve open
      if (force_off) begin
         n.out = 1'b0;
         n.cnt = 8'h00;
      end else if (tgt == r.out) begin
         n.cnt = 8'h00;
      end else if (tgt && n.cnt >= on_delay) begin
         n.out = 1'b1;
         n.cnt = 8'h00;
      end else if (!tgt && n.cnt >= off_delay) begin
         n.out = 1'b0;
         n.cnt = 8'h00;
      end else if (ms_tick && r.cnt != 8'hFF) begin
         n.cnt = r.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

endmodule

// ---- hdl/valve_out_defines.svh ----
`ifndef VALVE_OUT_DEFINES_SVH
`define VALVE_OUT_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_MASK  8'h0C
`define OFS_CH0       8'h10
`define OFS_CH_LAST   8'h1C

// Channel configuration fields
`define CF_SIM        0
`define CF_ERR_LO     1
`define CF_INV        3
`define CF_LFD        4
`define CF_NOPULSE    5
`define CF_SUBST      6
`define CF_SIMVAL     7
`define CF_SIMINV     8
`define CF_OND_LO     16
`define CF_OFFD_LO    24

// Control and interrupt fields
`define CT_ACTIVE     0
`define IRQ_WD_OFF    4

// Reset values
`define CTRL_RST      32'h0000_0001
`define CH_RST        32'h0000_0010
`define MASK_RST      5'h00

// Timing
`define CLK_MHZ       200
`define WD_TIME_MS    500
`define WD_CYC        (`WD_TIME_MS * 1000 * `CLK_MHZ)
`define MS_CYC        (1000 * `CLK_MHZ)
`define TP_WIDTH_NS   2000
`define TP_CYC        ((`TP_WIDTH_NS * `CLK_MHZ + 999) / 1000)
`define TP_PERIOD_MS  100
`define TP_PERIOD_CYC (`TP_PERIOD_MS * 1000 * `CLK_MHZ)
`define WD_FAILS      3

`endif

// ---- hdl/valve_out_pkg.sv ----
package valve_out_pkg;

   typedef enum logic [2:0] {
      WD_RUN  = 3'h1,
      WD_PEND = 3'h2,
      WD_OFF  = 3'h4
   } wd_state_t;

   typedef enum logic [1:0] {
      ERR_CURRENT = 2'h0,
      ERR_SUBST   = 2'h1,
      ERR_LAST    = 2'h2
   } err_mode_t;

endpackage

// ---- hdl/valve_output_channel_control.sv ----
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "valve_out_defines.svh"
// Functional notes
// - Line fault detection is enabled per channel by its own config bit.
// - A brief test current pulse checks the valve circuit without actuating.
// - A per-channel bit suppresses the test pulse for lamps or sounders.
// - Three failed link attempts, then outputs switch off after 500 ms.
// - Normal mode drives the value received from the bus.
// - Simulation mode drives the configured simulation value instead.
// - A watchdog error (three failed attempts) or invalid data applies the configured error strategy.
// - A line fault is only reported, never starting the error strategy.
// - Current-value mode keeps passing received or simulated value.
// - Substitute mode drives the per-channel substitute value.
// - Last-valid mode holds the last valid value before the fault.
// - Inversion flips the logical output level.
// - Channel activity follows the single module-wide active setting.
// - ON delay in ms filters out short high pulses.
// - OFF delay in ms stretches pulses by delaying falls.
// - Substitute is 0 or 1 and always reported as invalid data.
// - Simulation value with invalid status enters the substitute strategy.
module valve_output_channel_control #(
   parameter int WD_CYCLES  = `WD_CYC,
   parameter int MS_CYCLES  = `MS_CYC,
   parameter int TP_PERIOD  = `TP_PERIOD_CYC
) (
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Communication unit
   input  wire logic [3:0]  bus_val,
   input  wire logic [3:0]  bus_inv,
   input  wire logic        bus_upd,
   input  wire logic        comm_ok,
   input  wire logic        comm_fail,
   output logic [3:0]       rsp_invalid,
   // Field side
   output logic [3:0]       valve_out,
   output logic [3:0]       test_pulse,
   input  wire logic [3:0]  line_fault_in,
   output logic [3:0]       line_fault,
   // Interrupt
   output logic             irq
);

   localparam int NCH = 4;

   typedef struct packed {
      logic                         active;
      logic [NCH-1:0][31:0]         cfg;
      logic [3:0]                   bval;
      logic [3:0]                   binv;
      logic                         bupd;
      logic [1:0]                   fails;
      valve_out_pkg::wd_state_t     wd;
      logic [26:0]                  wd_cnt;
      logic [26:0]                  ms_cnt;
      logic                         ms_tick;
      logic [26:0]                  tp_cnt;
      logic [3:0]                   tp;
      logic [3:0]                   sync1;
      logic [3:0]                   sync2;
      logic [3:0]                   fault;
      logic [3:0]                   rinv;
      logic [4:0]                   irq_stat;
      logic [4:0]                   irq_mask;
      logic [31:0]                  rdata;
      logic                         err;
   } state_t;

   state_t r;
   state_t n;

   logic [3:0] ch_out;
   logic [3:0] ch_last;
   logic       wd_err;
   logic       force_off;

   assign wd_err    = (r.wd != valve_out_pkg::WD_RUN);
   // Inactive module keeps every valve de-energised
   assign force_off = (r.wd == valve_out_pkg::WD_OFF) || !r.active;

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
         valve_channel u_ch (
            .pclk        (pclk),
            .presetn     (presetn),
            .ce          (ce),
            .ms_tick     (r.ms_tick),
            .sim_mode    (r.cfg[gi][`CF_SIM]),
            .err_mode    (r.cfg[gi][`CF_ERR_LO +: 2]),
            .invert      (r.cfg[gi][`CF_INV]),
            .subst_val   (r.cfg[gi][`CF_SUBST]),
            .sim_val     (r.cfg[gi][`CF_SIMVAL]),
            .sim_invalid (r.cfg[gi][`CF_SIMINV]),
            .on_delay    (r.cfg[gi][`CF_OND_LO +: 8]),
            .off_delay   (r.cfg[gi][`CF_OFFD_LO +: 8]),
            .bus_val     (r.bval[gi]),
            .bus_inv     (r.binv[gi]),
            .bus_upd     (r.bupd),
            .wd_err      (wd_err),
            .force_off   (force_off),
            .valve_out   (ch_out[gi]),
            .last_valid  (ch_last[gi])
         );
      end
   endgenerate

   assign valve_out   = ch_out;
   assign test_pulse  = r.tp;
   assign line_fault  = r.fault;
   assign rsp_invalid = r.rinv;
   assign prdata      = r.rdata;
   assign pslverr     = r.err;
   // Reads are captured in setup, so no wait state is needed
   assign pready      = 1'b1;
   assign irq         = |(r.irq_stat & r.irq_mask);

   always_comb begin
      logic       wr;
      logic       rd;
      logic       hit;
      logic [4:0] set;
      logic [4:0] clr;
      logic [3:0] lfd;
      logic [3:0] nopulse;
      integer     i;
      wr      = psel && penable && pwrite;
      rd      = psel && !penable;
      hit     = 1'b0;
      set     = 5'h00;
      clr     = 5'h00;
      lfd     = 4'h0;
      nopulse = 4'h0;
      n       = r;
      for (i = 0; i < NCH; i = i + 1) begin
         lfd[i]     = r.cfg[i][`CF_LFD];
         nopulse[i] = r.cfg[i][`CF_NOPULSE];
      end

      // Millisecond time base for ON and OFF delays
      if (r.ms_cnt == 27'(MS_CYCLES - 1)) begin
         n.ms_cnt  = 27'h0;
         n.ms_tick = 1'b1;
      end else begin
         n.ms_cnt  = r.ms_cnt + 27'h1;
         n.ms_tick = 1'b0;
      end

      n.bupd = bus_upd;
      if (bus_upd) begin
         n.bval = bus_val;
         n.binv = bus_inv;
      end

      // Watchdog: counts failed attempts, then the off timer
      unique case (r.wd)
         valve_out_pkg::WD_PEND: begin
            if (r.wd_cnt == 27'(WD_CYCLES - 1)) begin
               n.wd = valve_out_pkg::WD_OFF;
               set[`IRQ_WD_OFF] = 1'b1;
            end else begin
               n.wd_cnt = r.wd_cnt + 27'h1;
            end
         end
         valve_out_pkg::WD_OFF: n.wd = r.wd;
         valve_out_pkg::WD_RUN: n.wd = r.wd;
      endcase
      // Fails saturate at three; further fails wait for a success
      if (comm_ok) begin
         n.fails = 2'h0;
         n.wd    = valve_out_pkg::WD_RUN;
         n.wd_cnt = 27'h0;
      end else if (comm_fail && r.wd == valve_out_pkg::WD_RUN) begin
         if (r.fails == 2'(`WD_FAILS - 1)) begin
            n.wd     = valve_out_pkg::WD_PEND;
            n.wd_cnt = 27'h0;
            n.fails  = 2'(`WD_FAILS);
         end else begin
            n.fails = r.fails + 2'h1;
         end
      end

      // Test pulse only on off valves, so energy stays below pull-in
      if (r.tp_cnt == 27'(TP_PERIOD - 1)) begin
         n.tp_cnt = 27'h0;
      end else begin
         n.tp_cnt = r.tp_cnt + 27'h1;
      end
      for (i = 0; i < NCH; i = i + 1) begin
         n.tp[i] = (r.tp_cnt < 27'(`TP_CYC)) && r.active
                   && lfd[i] && !nopulse[i] && !ch_out[i];
      end

      // Line fault sense: reported, never fed to the error strategy
      n.sync1 = line_fault_in;
      n.sync2 = r.sync1;
      n.fault = r.sync2 & lfd;
      set[3:0] = n.fault & ~r.fault;

      // Invalid status returned per channel
      // Sim mode ignores bus invalid, matching the channel's own fault
      for (i = 0; i < NCH; i = i + 1) begin
         n.rinv[i] = (r.cfg[i][`CF_SIM] && r.cfg[i][`CF_SIMINV])
                     || (((r.binv[i] && !r.cfg[i][`CF_SIM])
                          || wd_err)
                         && r.cfg[i][`CF_ERR_LO +: 2]
                            == valve_out_pkg::ERR_SUBST);
      end

      // Register writes
      if (wr) begin
         if (paddr == `OFS_CTRL) begin
            n.active = pwdata[`CT_ACTIVE];
         end else if (paddr == `OFS_IRQ_STAT) begin
            clr = pwdata[4:0];
         end else if (paddr == `OFS_IRQ_MASK) begin
            n.irq_mask = pwdata[4:0];
         end else if (paddr >= `OFS_CH0 && paddr <= `OFS_CH_LAST
                      && paddr[1:0] == 2'h0) begin
            n.cfg[paddr[3:2]] = pwdata;
         end
      end
      // Set beats clear in the same cycle
      n.irq_stat = (r.irq_stat & ~clr) | set;

      // Register reads captured in the setup phase
      if (rd) begin
         n.rdata = 32'h0;
         hit     = 1'b1;
         if (paddr == `OFS_CTRL) begin
            n.rdata[`CT_ACTIVE] = r.active;
         end else if (paddr == `OFS_STATUS) begin
            n.rdata[3:0]   = ch_out;
            n.rdata[7:4]   = r.fault;
            n.rdata[11:8]  = ch_last;
            n.rdata[14:12] = r.wd;
            n.rdata[17:16] = r.fails;
            n.rdata[23:20] = r.rinv;
         end else if (paddr == `OFS_IRQ_STAT) begin
            n.rdata[4:0] = r.irq_stat;
         end else if (paddr == `OFS_IRQ_MASK) begin
            n.rdata[4:0] = r.irq_mask;
         end else if (paddr >= `OFS_CH0 && paddr <= `OFS_CH_LAST
                      && paddr[1:0] == 2'h0) begin
            n.rdata = r.cfg[paddr[3:2]];
         end else begin
            hit = 1'b0;
         end
         n.err = !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.active   <= 1'(`CTRL_RST >> `CT_ACTIVE);
         r.cfg      <= {NCH{`CH_RST}};
         r.bval     <= 4'h0;
         r.binv     <= 4'h0;
         r.bupd     <= 1'b0;
         r.fails    <= 2'h0;
         r.wd       <= valve_out_pkg::WD_RUN;
         r.wd_cnt   <= 27'h0;
         r.ms_cnt   <= 27'h0;
         r.ms_tick  <= 1'b0;
         r.tp_cnt   <= 27'h0;
         r.tp       <= 4'h0;
         r.sync1    <= 4'h0;
         r.sync2    <= 4'h0;
         r.fault    <= 4'h0;
         r.rinv     <= 4'h0;
         r.irq_stat <= 5'h00;
         r.irq_mask <= `MASK_RST;
         r.rdata    <= 32'h0;
         r.err      <= 1'b0;
      end else if (ce) begin
         r <= n;
      end
   end

endmodule
